// [rtl/tmirq_pkg.sv]
// Constants for the timer match interrupt controller
package tmirq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_FLAGS   = 8'h00;
    localparam logic [7:0] ADDR_ENABLE  = 8'h04;
    localparam logic [7:0] ADDR_GROUP   = 8'h08;
    localparam logic [7:0] ADDR_CORE    = 8'h0c;
    localparam logic [7:0] ADDR_ISTAT   = 8'h10;
    localparam logic [7:0] ADDR_IMASK   = 8'h14;
    // GROUP register fields
    localparam int GRP_FLAG_BIT   = 0;
    localparam int GRP_ENABLE_BIT = 1;
    // CORE register fields
    localparam int CORE_GIE_BIT   = 0;
    localparam int CORE_SLEEP_BIT = 1;
    localparam int CORE_DEPTH_LSB = 8;
    // Interrupt status bits
    localparam int IST_SERVICE_BIT = 0;
    localparam int IST_WAKE_BIT    = 1;
    localparam int IST_WIDTH       = 2;
    // Reset values
    localparam logic RST_GIE = 1'b0;
    // Sequencer opcodes from the core
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_CALL = 2'h1;
    localparam logic [1:0] OP_RET  = 2'h2;
    localparam logic [1:0] OP_RETURN_WITH_IRQ_REENABLE = 2'h3;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : tmirq_pkg

// [rtl/pc_stack.sv]
// Return address stack for the program sequencer
`timescale 1ns/10ps
`default_nettype none
module pc_stack
    import tmirq_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW    = 13
)(
    // Clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // Push and pop
    input  wire logic                       push,
    input  wire logic [AW-1:0]              push_addr,
    input  wire logic                       pop,
    output logic      [AW-1:0]              top_addr,
    // Occupancy
    output logic      [$clog2(DEPTH+1)-1:0] depth,
    output logic                            full
);
    logic [AW-1:0] mem [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] level;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level <= '0;
        else if (push && level != DEPTH[$clog2(DEPTH+1)-1:0])
            level <= level + 1'b1;
        else if (pop && level != '0)
            level <= level - 1'b1;
    end

    always_ff @(posedge hclk)
    begin
        if (push && level != DEPTH[$clog2(DEPTH+1)-1:0])
            mem[level[$clog2(DEPTH)-1:0]] <= push_addr;
    end

    assign depth    = level;
    assign full     = (level == DEPTH[$clog2(DEPTH+1)-1:0]);
    assign top_addr = (level == '0) ? '0 : mem[level[$clog2(DEPTH)-1:0] - 1'b1];
endmodule // pc_stack
`default_nettype wire

// [rtl/tmirq_ctrl.sv]
// Timer match interrupt controller with wake-up and AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tmirq_ctrl
    import tmirq_pkg::*;
#(
    parameter int          NTM         = 2,
    parameter int          STACK_DEPTH = 8,
    parameter int          AW          = 13,
    parameter logic [12:0] GROUP_VECTOR = 13'h0010
)(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [7:0]      haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // Timer comparator match pulses
    input  wire logic [NTM-1:0]  match_a,
    input  wire logic [NTM-1:0]  match_p,
    // Core sequencer
    input  wire logic            insn_boundary,
    input  wire logic [1:0]      seq_op,
    input  wire logic [AW-1:0]   pc_now,
    input  wire logic            sleep_req,
    output logic                 irq_call,
    output logic      [AW-1:0]   irq_vector,
    output logic                 ret_valid,
    output logic      [AW-1:0]   ret_addr,
    output logic                 asleep,
    output logic                 wakeup,
    output logic                 irq
);
    localparam int NSRC = 2 * NTM;
    localparam int DW   = $clog2(STACK_DEPTH+1);

    logic [NSRC-1:0] src_flag;
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] src_set;
    logic [NSRC-1:0] sw_clr;
    logic [NSRC-1:0] sw_set;
    logic            group_flag;
    logic            group_en;
    logic            global_irq_enable;
    logic            sleeping;
    logic [IST_WIDTH-1:0] istat;
    logic [IST_WIDTH-1:0] imask;
    logic [IST_WIDTH-1:0] ev;
    logic            take;
    logic            do_ret;
    logic            stk_full;
    logic [AW-1:0]   stk_top;
    logic [DW-1:0]   stk_depth;
    logic            any_rise;
    // Bus phase capture
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic            wr_now;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Two sources per timer: A in low half, P in high half
    assign src_set = {match_p, match_a};

    assign wr_now = wr_pend;
    always_comb
    begin
        sw_clr = '0;
        sw_set = '0;
        if (wr_now && hit(wr_addr, ADDR_FLAGS))
        begin
            sw_set = hwdata[NSRC-1:0];
            sw_clr = ~hwdata[NSRC-1:0];
        end
    end

    // Flags sticky regardless of enable; match beats clear
    // Software may write a flag high before sleeping
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            src_flag <= '0;
        else
            src_flag <= (src_flag & ~sw_clr) | sw_set | src_set;
    end

    // Low-to-high transition of any request flag
    // No enable term in the wake condition
    // Group term follows the group flag's own next value, so a rewrite of a set flag is no rise
    assign any_rise = |(~src_flag & (src_set | sw_set))
                      || (!group_flag && (|src_set
                          || (!take && wr_now && hit(wr_addr, ADDR_GROUP) && hwdata[GRP_FLAG_BIT])));

    // Take only at an instruction boundary
    // All three enables and room on the stack
    assign take = insn_boundary && !sleeping && global_irq_enable && group_en
                  && |(src_flag & src_en) && !stk_full && seq_op == OP_NONE;
    assign do_ret = seq_op == OP_RET || seq_op == OP_RETURN_WITH_IRQ_REENABLE;

    // Group flag set by any match pulse, not by a software write to the flags
    // Service clears group flag, source flags untouched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            group_flag <= 1'b0;
        else if (|src_set)
            group_flag <= 1'b1;
        else if (take)
            group_flag <= 1'b0;
        else if (wr_now && hit(wr_addr, ADDR_GROUP))
            group_flag <= hwdata[GRP_FLAG_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_en   <= '0;
            group_en <= 1'b0;
            imask    <= '0;
        end
        else if (wr_now)
        begin
            if (hit(wr_addr, ADDR_ENABLE))
                src_en <= hwdata[NSRC-1:0];
            else if (hit(wr_addr, ADDR_GROUP))
                group_en <= hwdata[GRP_ENABLE_BIT];
            else if (hit(wr_addr, ADDR_IMASK))
                imask <= hwdata[IST_WIDTH-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            global_irq_enable <= RST_GIE;
        else if (take)
            global_irq_enable <= 1'b0;
        else if (seq_op == OP_RETURN_WITH_IRQ_REENABLE && insn_boundary)
            global_irq_enable <= 1'b1;
        else if (wr_now && hit(wr_addr, ADDR_CORE))
            global_irq_enable <= hwdata[CORE_GIE_BIT];
    end

    // Only the program counter goes on the stack
    pc_stack #(
        .DEPTH     (STACK_DEPTH),
        .AW        (AW)
    ) u_stack (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .push      (take || (seq_op == OP_CALL && insn_boundary)),
        .push_addr (pc_now),
        .pop       (do_ret && insn_boundary),
        .top_addr  (stk_top),
        .depth     (stk_depth),
        .full      (stk_full)
    );

    // Sleep state: entered on request, left on any flag rise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sleeping <= 1'b0;
        else if (sleeping && any_rise)
            sleeping <= 1'b0;
        else if (sleep_req)
            sleeping <= 1'b1;
    end

    // Sequencer outputs, registered
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_call   <= 1'b0;
            irq_vector <= '0;
            ret_valid  <= 1'b0;
            ret_addr   <= '0;
            wakeup     <= 1'b0;
        end
        else
        begin
            irq_call   <= take;
            irq_vector <= GROUP_VECTOR[AW-1:0];
            ret_valid  <= do_ret && insn_boundary;
            ret_addr   <= stk_top;
            wakeup     <= sleeping && any_rise;
        end
    end
    assign asleep = sleeping;

    // Sticky interrupt status, write one to clear, event wins
    assign ev = {sleeping && any_rise, take};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            istat <= '0;
        else if (wr_now && hit(wr_addr, ADDR_ISTAT))
            istat <= (istat & ~hwdata[IST_WIDTH-1:0]) | ev;
        else
            istat <= istat | ev;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(istat & imask);
    end

    // AHB-Lite: zero wait state, address captured for write data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata  <= '0;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            wr_addr <= haddr;
            hrdata  <= '0;
            if (hsel && htrans == HTRANS_NONSEQ && !hwrite)
            begin
                if (hit(haddr, ADDR_FLAGS))
                    hrdata <= 32'(src_flag);
                else if (hit(haddr, ADDR_ENABLE))
                    hrdata <= 32'(src_en);
                else if (hit(haddr, ADDR_GROUP))
                    hrdata <= 32'({group_en, group_flag});
                else if (hit(haddr, ADDR_CORE))
                    hrdata <= 32'({stk_depth, 6'h00, sleeping, global_irq_enable});
                else if (hit(haddr, ADDR_ISTAT))
                    hrdata <= 32'(istat);
                else if (hit(haddr, ADDR_IMASK))
                    hrdata <= 32'(imask);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Global enable low the cycle after a take
    chk_take_clears_gie: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> !global_irq_enable)
        else $error("global enable not cleared on entry");

    chk_call_needs_enables: assert property (@(posedge hclk) disable iff (!hresetn)
        take |-> (global_irq_enable && group_en && !stk_full && |(src_flag & src_en)))
        else $error("call taken without enables");

    chk_service_keeps_src: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !wr_now) |=> (src_flag == ($past(src_flag) | $past(src_set))))
        else $error("source flag lost on service");

    // Flag holds without a clear write
    chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (|src_flag && !wr_now) |=> ((src_flag & $past(src_flag)) == $past(src_flag)))
        else $error("flag dropped without software clear");

    // Match sets its flag next cycle
    chk_match_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        |src_set |=> ((src_flag & $past(src_set)) == $past(src_set)))
        else $error("match did not set flag");

    chk_group_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        |src_set |=> group_flag)
        else $error("group flag not set");

    // Flag rise in sleep wakes within one cycle
    sequence s_sleep_rise;
        sleeping && any_rise;
    endsequence
    chk_wake_on_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        s_sleep_rise |=> (wakeup && !sleeping))
        else $error("no wake on flag rise");

    // Wake happens even with enables clear
    chk_wake_no_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        (sleeping && |(~src_flag & src_set & ~src_en)) |=> !sleeping)
        else $error("enable gated wake-up");

    chk_return_with_irq_reenable_sets_gie: assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_op == OP_RETURN_WITH_IRQ_REENABLE && insn_boundary && !take) |=> global_irq_enable)
        else $error("interrupt return left enable low");

    // Plain return does not raise it
    chk_ret_keeps_gie: assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_op == OP_RET && !global_irq_enable && !wr_now) |=> !global_irq_enable)
        else $error("plain return raised enable");

    chk_call_boundary: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_call |-> $past(insn_boundary))
        else $error("call off boundary");

    chk_entry_push: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> stk_depth == $past(stk_depth) + 1'b1)
        else $error("entry did not push pc");
endmodule // tmirq_ctrl
`default_nettype wire

// [tb/core_model.sv]
// Behavioural core sequencer that serves interrupts and returns
`timescale 1ns/10ps
`default_nettype none
module core_model
    import tmirq_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Bench control
    input  wire logic        run,
    input  wire logic [1:0]  ret_kind,
    // Sequencer side
    input  wire logic        irq_call,
    output logic             insn_boundary,
    output logic [1:0]       seq_op,
    output logic [12:0]      pc_now,
    output logic [12:0]      saved_pc
);
    logic [1:0]  phase;
    logic [5:0]  svc;
    logic [12:0] last_pc;
    assign insn_boundary = run && (phase == 2'h3);
    assign seq_op = (svc == 6'h01 && insn_boundary) ? ret_kind : OP_NONE;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= 2'h0;
            pc_now <= 13'h0100;
            last_pc <= 13'h0000;
        end
        else
        begin
            phase <= phase + 2'h1;
            if (insn_boundary)
            begin
                last_pc <= pc_now;
                pc_now <= pc_now + 13'h0001;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            svc <= 6'h00;
            saved_pc <= 13'h0000;
        end
        else if (irq_call)
        begin
            svc <= 6'h28;
            saved_pc <= last_pc;
        end
        else if (svc > 6'h01 || (svc == 6'h01 && insn_boundary))
            svc <= svc - 6'h01;
    end
endmodule // core_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the timer match interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import tmirq_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, ret_kind, match_a, match_p, seq_op;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        run, sleep_req, irq_call, ret_valid, asleep, wakeup, irq, insn_boundary;
    logic [12:0] pc_now, saved_pc, irq_vector, ret_addr, last_ret;
    int          num_errors = 0;
    int          total_checks = 0;
    int          calls = 0;
    int          rets = 0;
    int          wakes = 0;
    always #2 hclk = ~hclk;
    always @(posedge hclk)
    begin
        if (irq_call === 1'b1) calls++;
        if (wakeup === 1'b1) wakes++;
        if (ret_valid === 1'b1)
        begin
            rets++;
            last_ret = ret_addr;
        end
    end
    tmirq_ctrl #(.NTM(2), .STACK_DEPTH(8), .AW(13), .GROUP_VECTOR(13'h0010)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .match_a(match_a), .match_p(match_p),
        .insn_boundary(insn_boundary), .seq_op(seq_op), .pc_now(pc_now), .sleep_req(sleep_req),
        .irq_call(irq_call), .irq_vector(irq_vector), .ret_valid(ret_valid), .ret_addr(ret_addr),
        .asleep(asleep), .wakeup(wakeup), .irq(irq));
    core_model core (
        .hclk(hclk), .hresetn(hresetn), .run(run), .ret_kind(ret_kind), .irq_call(irq_call),
        .insn_boundary(insn_boundary), .seq_op(seq_op), .pc_now(pc_now), .saved_pc(saved_pc));
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_cnt(ref int c, input int t);
        for (int n = 0; n < 300 && c < t; n++)
            @(posedge hclk);
        if (c < t)
        begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            num_errors++;
            give_verdict();
        end
    endtask
    // One single word transfer, read data taken at the data phase end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [1:0] a, input logic [1:0] p);
        match_a <= a;
        match_p <= p;
        @(posedge hclk);
        match_a <= 2'h0;
        match_p <= 2'h0;
    endtask
    task automatic s_reset();
        chk(hreadyout, 1);
        chk(hresp, 0);
        chk(irq, 0);
        rd(ADDR_CORE, 32'h0);
        rd(ADDR_FLAGS, 32'h0);
    endtask
    task automatic s_refuse();
        wr(ADDR_IMASK, 32'h1);
        wr(ADDR_GROUP, 32'h2);
        wr(ADDR_CORE, 32'h1);
        pulse(2'h1, 2'h0);
        run <= 1'b1;
        repeat (12) @(posedge hclk);
        chk(calls, 0);
        rd(ADDR_FLAGS, 32'h1);
        rd(ADDR_GROUP, 32'h3);
        run <= 1'b0;
        wr(ADDR_ENABLE, 32'h1);
        repeat (12) @(posedge hclk);
        chk(calls, 0);
    endtask
    task automatic s_take();
        run <= 1'b1;
        wait_cnt(calls, 1);
        chk(irq_vector, 32'h10);
        rd(ADDR_CORE, 32'h100);
        rd(ADDR_GROUP, 32'h2);
        rd(ADDR_FLAGS, 32'h1);
        rd(ADDR_ISTAT, 32'h1);
        chk(irq, 1);
        wr(ADDR_ISTAT, 32'h1);
        rd(ADDR_ISTAT, 32'h0);
        chk(irq, 0);
        wr(ADDR_FLAGS, 32'h0);
        wait_cnt(rets, 1);
        chk(last_ret, saved_pc);
        repeat (2) @(posedge hclk);
        rd(ADDR_CORE, 32'h1);
    endtask
    task automatic s_plain_ret();
        ret_kind <= OP_RET;
        wr(ADDR_ENABLE, 32'h8);
        pulse(2'h0, 2'h2);
        wait_cnt(calls, 2);
        wr(ADDR_FLAGS, 32'h0);
        wait_cnt(rets, 2);
        repeat (2) @(posedge hclk);
        rd(ADDR_CORE, 32'h0);
    endtask
    task automatic s_wake();
        int w0;
        run <= 1'b0;
        wr(ADDR_ISTAT, 32'h3);
        wr(ADDR_FLAGS, 32'h1);
        wr(ADDR_GROUP, 32'h3);
        w0 = wakes;
        sleep_req <= 1'b1;
        @(posedge hclk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(asleep, 1);
        pulse(2'h1, 2'h0);
        repeat (10) @(posedge hclk);
        chk(wakes, w0);
        chk(asleep, 1);
        pulse(2'h2, 2'h0);
        wait_cnt(wakes, w0 + 1);
        repeat (2) @(posedge hclk);
        chk(asleep, 0);
        rd(ADDR_ISTAT, 32'h2);
        chk(irq, 0);
        wr(ADDR_IMASK, 32'h3);
        repeat (2) @(posedge hclk);
        chk(irq, 1);
        wr(ADDR_ISTAT, 32'h2);
        repeat (2) @(posedge hclk);
        chk(irq, 0);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
    endtask
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, run, sleep_req} = 4'h0;
        {haddr, htrans, hsize, hwdata, match_a, match_p} = '0;
        ret_kind = OP_RETURN_WITH_IRQ_REENABLE;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset();
        s_refuse();
        s_take();
        s_plain_ret();
        s_wake();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
